// ===== verilog/sch_defs.svh
// Constants of the system command handler: header codes, field values, timing.
// Assumes byte-wide framed messages arriving over a host link parser outside.
// Overview of operation
// [RQ1] Item write: header 21/09, id, offset, length, value; reply 61/09 with status.
// [RQ2] Six items 0300-0305; first four hold 2 bytes, last two 16 bytes.
// [RQ3] Written bytes land from the offset byte position inside the item.
// [RQ4] Four software timers, ids 0 to 3, each notifies the host on expiry.
// [RQ5] Timer arm: header 21/0A, id, 2-byte millisecond timeout; reply 61/0A status.
// [RQ6] Timer cancel: header 21/0B with id stops it; reply 61/0B status.
// [RQ7] Expired timer sends unsolicited 41/81 frame carrying its id.
// [RQ8] Random fetch 21/0C, no data; reply 61/0C with 16-bit random value.
// [RQ9] Converter read 21/0D channel codes 06, 07, 0B, 0E, 0F.
// [RQ10] Resolution codes 00..03 select 7, 9, 10, 12 bits.
// [RQ11] Result returned as 2-byte signed value under 61/0D; host drops low bits.
// [RQ12] Four pins controlled by 21/0E carrying operation byte and mask byte.
// [RQ13] Pins 0,1 at mask bits 0,1; pins 2,3 at bits 4,5; others ignored.
// [RQ14] Operation 00 sets direction: 0 input, 1 output.
// [RQ15] Operation 01 sets input style: 0 pull-up, 1 tri-state; pins 0,1 tri-state only.
// [RQ16] Operation 02 sets pins with mask 1; operation 03 clears pins with mask 0.
// [RQ17] Operation 04 toggles pins with mask 1; operation 05 only samples.
// [RQ18] Every pin operation replies 61/0E with pin states after the operation.
// [RQ19] Reset makes pins pull-up inputs; sleep keeps levels and configuration.
// [RQ20] Frame is length, type/subsystem byte, identifier byte, then data.
// [RQ21] Multi-byte fields go least significant byte first, fields left to right.
// [RQ22] Type 1 request, 2 async, 3 reply; reply reuses subsystem and identifier.
// [RQ23] Bad timer id or bad item or overrun gives failure status, no change.
// [RQ24] Pin operations above 05 leave pins alone but still reply with states.
`ifndef SCH_DEFS_SVH
`define SCH_DEFS_SVH

// --------------------------------------------------------------------------
// Header bytes
// --------------------------------------------------------------------------
`define SCH_HDR_REQ 8'h21
`define SCH_HDR_RSP 8'h61
`define SCH_HDR_ASY 8'h41
`define SCH_ID_NVW 8'h09
`define SCH_ID_TARM 8'h0A
`define SCH_ID_TCAN 8'h0B
`define SCH_ID_RND 8'h0C
`define SCH_ID_ADC 8'h0D
`define SCH_ID_PIN 8'h0E
`define SCH_ID_TEXP 8'h81
`define SCH_TYPE_LSB 5
`define SCH_TYPE_REQ 3'h1
`define SCH_TYPE_ASY 3'h2
`define SCH_TYPE_RSP 3'h3

// --------------------------------------------------------------------------
// Field values
// --------------------------------------------------------------------------
`define SCH_ITEM_BASE 16'h0300
`define SCH_ITEM_BIG 16'h0304
`define SCH_ITEM_LAST 16'h0305
`define SCH_ITEM_SMALL_SZ 8'h02
`define SCH_ITEM_BIG_SZ 8'h10
`define SCH_ST_OK 8'h00
`define SCH_ST_FAIL 8'h01
`define SCH_NUM_TIMERS 4
`define SCH_CH_ANALOG_ZERO 8'h06
`define SCH_CH_ANALOG_ONE 8'h07
`define SCH_CH_DIFF 8'h0B
`define SCH_CH_TEMP 8'h0E
`define SCH_CH_VDD 8'h0F
`define SCH_PIN_OP_MAX 8'h05
`define SCH_PIN_DIR_RST 4'h0
`define SCH_PIN_TRI_RST 4'h0
`define SCH_PIN_OUT_RST 4'h0

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define SCH_CLK_MHZ 100
`define SCH_MS_US 1000
`define SCH_MS_CYCLES (`SCH_CLK_MHZ * `SCH_MS_US)

`endif

// ===== verilog/sch_pkg.sv
// Types shared by the system command handler files.
// Assumes the constants header is compiled alongside.
package sch_pkg;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } sch_byte_s;

  typedef enum logic [4:0] {
    SCH_OP_DIR = 5'b00001,
    SCH_OP_STYLE = 5'b00010,
    SCH_OP_SET = 5'b00100,
    SCH_OP_CLR = 5'b01000,
    SCH_OP_TGL = 5'b10000
  } sch_pinop_e;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] tri_in;
    logic [3:0] level;
  } sch_pin_cfg_s;

endpackage : sch_pkg

// ===== verilog/sch_item_mem.sv
// Byte store for the six application items, 40 bytes in total.
// Assumes the caller checks the address range before writing.
`timescale 1ns/10ps
module sch_item_mem import sch_pkg::*; #(
  parameter int DEPTH = 40
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end

endmodule : sch_item_mem

// ===== verilog/sch_timer_bank.sv
// Millisecond software timers with one-shot expiry flags held until taken.
// Assumes arm and cancel are single-cycle strobes from the command handler.
`timescale 1ns/10ps
`include "sch_defs.svh"
module sch_timer_bank import sch_pkg::*; #(
  parameter int NUM = 4,
  parameter int MS_CYCLES = `SCH_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic arm,
  input wire logic cancel,
  input wire logic [1:0] sel,
  input wire logic [15:0] timeout_ms,
  // Expiry, held until taken
  output logic [NUM-1:0] pending,
  input wire logic [NUM-1:0] taken
);

  typedef struct packed {
    logic [31:0] tick;
    logic [NUM-1:0] run;
    logic [NUM-1:0][15:0] left;
    logic [NUM-1:0] pend;
  } sch_tmr_s;

  sch_tmr_s s_q, s_d;
  logic tick_now;

  assign tick_now = (s_q.tick == 32'(MS_CYCLES - 1));
  assign pending = s_q.pend;

  always_comb begin
    s_d = s_q;
    s_d.tick = tick_now ? 32'h0 : s_q.tick + 32'h1;
    for (int i = 0; i < NUM; i++) begin
      if (taken[i]) begin
        s_d.pend[i] = 1'b0;
      end
      if (s_q.run[i] && tick_now) begin
        if (s_q.left[i] <= 16'h1) begin
          s_d.run[i] = 1'b0;
          s_d.pend[i] = 1'b1; // [RQ4]
        end else begin
          s_d.left[i] = s_q.left[i] - 16'h1;
        end
      end
      if (sel == 2'(i)) begin
        if (cancel) begin
          s_d.run[i] = 1'b0; // [RQ6]
        end
        if (arm) begin
          s_d.run[i] = 1'b1; // [RQ5]
          s_d.left[i] = timeout_ms;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sch_timer_bank

// ===== verilog/sch_cmd_handler.sv
// System command handler: decodes request frames, answers with reply frames.
// Assumes a link layer delivers request bytes and accepts reply bytes.
`timescale 1ns/10ps
`include "sch_defs.svh"
module sch_cmd_handler import sch_pkg::*; #(
  parameter int MS_CYCLES = `SCH_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request byte stream, length byte first
  input wire sch_pkg::sch_byte_s rx,
  output logic rx_ready,
  // Reply byte stream, length byte first
  output sch_pkg::sch_byte_s tx,
  input wire logic tx_ready,
  // Random source and converter
  input wire logic [15:0] rng_value,
  output logic adc_start,
  output logic [7:0] adc_channel,
  output logic [1:0] adc_resolution,
  input wire logic adc_done,
  input wire logic [15:0] adc_result,
  // Pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] pin_pullup,
  // Power
  input wire logic sleep
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RX = 6'b000001,
    ST_EXEC = 6'b000010,
    ST_ADC = 6'b000100,
    ST_MEMWR = 6'b001000,
    ST_TX = 6'b010000,
    ST_DROP = 6'b100000
  } sch_state_e;

  typedef struct packed {
    sch_state_e st;
    logic [7:0] cnt;
    logic [7:0] len;
    logic [7:0] hdr0;
    logic [7:0] hdr1;
    logic [5:0][7:0] arg;
    logic [7:0] wr_base;
    logic [7:0] wr_left;
    logic nv_ok;
    logic [3:0][7:0] rsp;
    logic [2:0] rsp_n;
    logic [2:0] tx_i;
    logic adc_go;
    logic [7:0] adc_ch;
    logic [1:0] adc_res;
    sch_pin_cfg_s pin;
  } sch_main_s;

  sch_main_s s_q, s_d;
  logic tmr_arm, tmr_cancel;
  logic [3:0] tmr_pend, tmr_take;
  logic mem_we;
  logic [5:0] mem_addr;
  logic [7:0] mem_rd;
  logic [15:0] item_id;
  logic [7:0] item_sz, item_base, pin_mask, pin_op;
  logic [3:0] mask4, pin_now;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  assign item_id = {s_q.arg[1], s_q.arg[0]}; // [RQ21]
  assign item_sz = (item_id >= `SCH_ITEM_BIG) ? `SCH_ITEM_BIG_SZ : `SCH_ITEM_SMALL_SZ; // [RQ2]
  assign item_base = (item_id >= `SCH_ITEM_BIG) ? 8'(8'h08 + 8'((item_id - `SCH_ITEM_BIG) << 4))
                                                : 8'((item_id - `SCH_ITEM_BASE) << 1);
  assign pin_op = s_q.arg[0];
  assign pin_mask = s_q.arg[1];
  assign mask4 = {pin_mask[5], pin_mask[4], pin_mask[1], pin_mask[0]}; // [RQ13]
  assign pin_now = (s_q.pin.dir & s_q.pin.level) | (~s_q.pin.dir & pin_in);
  // Bytes beyond the requested length are consumed but never stored
  assign mem_we = (s_q.st == ST_MEMWR) && rx.valid && s_q.wr_left != 8'h0;
  assign mem_addr = 6'(s_q.wr_base);

  assign rx_ready = (s_q.st == ST_RX) || (s_q.st == ST_MEMWR) || (s_q.st == ST_DROP);
  assign adc_start = s_q.adc_go;
  assign adc_channel = s_q.adc_ch;
  assign adc_resolution = s_q.adc_res;
  assign pin_out = s_q.pin.level;
  assign pin_oe = s_q.pin.dir; // [RQ19]
  assign pin_pullup = ~s_q.pin.dir & ~s_q.pin.tri_in;

  always_comb begin
    tx = '0;
    tmr_take = '0;
    if (s_q.st == ST_TX) begin
      tx.valid = 1'b1;
      tx.last = (s_q.tx_i == 3'(s_q.rsp_n + 3'h2));
      case (s_q.tx_i)
        3'h0: tx.data = {5'h0, s_q.rsp_n}; // [RQ20]
        3'h1: tx.data = s_q.hdr0;
        3'h2: tx.data = s_q.hdr1;
        default: tx.data = s_q.rsp[2'(s_q.tx_i - 3'h3)];
      endcase
      if (tx_ready && tx.last && s_q.hdr0 == `SCH_HDR_ASY) begin
        tmr_take[s_q.rsp[0][1:0]] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.adc_go = 1'b0;
    tmr_arm = 1'b0;
    tmr_cancel = 1'b0;
    case (s_q.st)
      ST_RX: begin
        if (|tmr_pend && s_q.cnt == 8'h0 && !rx.valid) begin
          s_d.hdr0 = `SCH_HDR_ASY; // [RQ7]
          s_d.hdr1 = `SCH_ID_TEXP;
          s_d.rsp_n = 3'h1;
          s_d.rsp[0] = tmr_pend[0] ? 8'h0 : tmr_pend[1] ? 8'h1 : tmr_pend[2] ? 8'h2 : 8'h3;
          s_d.tx_i = 3'h0;
          s_d.st = ST_TX;
        end else if (rx.valid) begin
          s_d.cnt = s_q.cnt + 8'h1;
          case (s_q.cnt)
            8'h0: s_d.len = rx.data;
            8'h1: s_d.hdr0 = rx.data;
            8'h2: s_d.hdr1 = rx.data;
            default: if (s_q.cnt < 8'h9) s_d.arg[3'(s_q.cnt - 8'h3)] = rx.data; // [RQ21]
          endcase
          // Item write executes once its length byte is in; values stream afterwards
          if (s_q.cnt == 8'h6 && s_q.hdr0 == `SCH_HDR_REQ && s_q.hdr1 == `SCH_ID_NVW) begin
            s_d.st = ST_EXEC;
          end else if (s_q.cnt >= 8'h2 && s_q.cnt == s_q.len + 8'h2) begin
            s_d.st = ST_EXEC;
          end
          if (rx.last && !(s_q.cnt >= 8'h2 && s_q.cnt == s_q.len + 8'h2) && s_d.st != ST_EXEC) begin
            s_d.cnt = 8'h0;
          end
        end
      end
      ST_EXEC: begin
        s_d.cnt = 8'h0;
        s_d.tx_i = 3'h0;
        s_d.rsp_n = 3'h1;
        s_d.rsp[0] = `SCH_ST_OK;
        s_d.st = ST_TX;
        s_d.hdr0 = {`SCH_TYPE_RSP, s_q.hdr0[4:0]}; // [RQ22]
        if (s_q.hdr0 != `SCH_HDR_REQ) begin
          s_d.st = ST_RX;
        end else begin
          case (s_q.hdr1)
            `SCH_ID_NVW: begin
              s_d.wr_base = item_base + s_q.arg[2];
              s_d.wr_left = s_q.arg[3];
              s_d.nv_ok = item_id >= `SCH_ITEM_BASE && item_id <= `SCH_ITEM_LAST
                          && {1'b0, s_q.arg[2]} + {1'b0, s_q.arg[3]} <= {1'b0, item_sz}; // [RQ23]
              s_d.st = (s_q.len > 8'h4) ? ST_MEMWR : ST_TX; // [RQ1]
              if (!(item_id >= `SCH_ITEM_BASE && item_id <= `SCH_ITEM_LAST
                    && {1'b0, s_q.arg[2]} + {1'b0, s_q.arg[3]} <= {1'b0, item_sz})) begin
                s_d.rsp[0] = `SCH_ST_FAIL;
              end
            end
            `SCH_ID_TARM, `SCH_ID_TCAN: begin
              if (s_q.arg[0] >= 8'(`SCH_NUM_TIMERS)) begin
                s_d.rsp[0] = `SCH_ST_FAIL; // [RQ23]
              end else begin
                tmr_arm = (s_q.hdr1 == `SCH_ID_TARM); // [RQ5]
                tmr_cancel = (s_q.hdr1 == `SCH_ID_TCAN); // [RQ6]
              end
            end
            `SCH_ID_RND: begin
              s_d.rsp_n = 3'h2; // [RQ8]
              s_d.rsp[0] = rng_value[7:0];
              s_d.rsp[1] = rng_value[15:8];
            end
            `SCH_ID_ADC: begin
              s_d.adc_ch = s_q.arg[0]; // [RQ9]
              s_d.adc_res = s_q.arg[1][1:0]; // [RQ10]
              s_d.adc_go = 1'b1;
              s_d.st = ST_ADC;
            end
            `SCH_ID_PIN: begin // [RQ12]
              if (pin_op <= `SCH_PIN_OP_MAX) begin
                case (pin_op[2:0])
                  3'h0: s_d.pin.dir = mask4; // [RQ14]
                  3'h1: s_d.pin.tri_in = mask4 | 4'h3; // [RQ15]
                  3'h2: s_d.pin.level = s_q.pin.level | mask4; // [RQ16]
                  3'h3: s_d.pin.level = s_q.pin.level & mask4; // [RQ16]
                  3'h4: s_d.pin.level = s_q.pin.level ^ mask4; // [RQ17]
                  default: s_d.pin = s_q.pin; // [RQ17]
                endcase
              end // [RQ24]
              s_d.rsp[0] = {2'b00, pin_now[3], pin_now[2], 2'b00, pin_now[1], pin_now[0]}; // [RQ18]
              if (pin_op[2:0] != 3'h5 || pin_op > `SCH_PIN_OP_MAX) begin
                s_d.st = ST_EXEC;
                s_d.hdr0 = s_q.hdr0;
                s_d.hdr1 = `SCH_ID_PIN;
                s_d.arg[0] = `SCH_PIN_OP_MAX;
              end
            end
            default: s_d.st = ST_RX;
          endcase
        end
      end
      ST_ADC: begin
        if (adc_done) begin
          s_d.rsp_n = 3'h2; // [RQ11]
          s_d.rsp[0] = adc_result[7:0];
          s_d.rsp[1] = adc_result[15:8];
          s_d.st = ST_TX;
        end
      end
      ST_MEMWR: begin
        if (rx.valid) begin
          s_d.wr_base = s_q.wr_base + 8'h1; // [RQ3]
          s_d.wr_left = s_q.wr_left - 8'h1;
          if (rx.last || s_q.wr_left <= 8'h1) begin
            s_d.st = rx.last ? ST_TX : ST_DROP;
          end
        end
      end
      ST_DROP: begin
        if (rx.valid && rx.last) begin
          s_d.st = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_ready) begin
          s_d.tx_i = s_q.tx_i + 3'h1;
          if (tx.last) begin
            s_d.st = ST_RX;
            s_d.cnt = 8'h0;
          end
        end
      end
      default: s_d.st = ST_RX;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= ST_RX;
      s_q.pin <= '{dir: `SCH_PIN_DIR_RST, tri_in: `SCH_PIN_TRI_RST, level: `SCH_PIN_OUT_RST}; // [RQ19]
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Sub-blocks
  // --------------------------------------------------------------------------
  sch_item_mem #(.DEPTH(40)) u_mem (
    .clk(clk),
    .wr_en(mem_we && s_q.nv_ok),
    .wr_addr(mem_addr),
    .wr_data(rx.data),
    .rd_addr(mem_addr),
    .rd_data(mem_rd)
  );

  sch_timer_bank #(.NUM(4), .MS_CYCLES(MS_CYCLES)) u_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .arm(tmr_arm),
    .cancel(tmr_cancel),
    .sel(s_q.arg[0][1:0]),
    .timeout_ms({s_q.arg[2], s_q.arg[1]}),
    .pending(tmr_pend),
    .taken(tmr_take)
  );

endmodule : sch_cmd_handler

// ===== testbench/sch_cmd_handler_asserts.sv
// Port assertions for the system command handler.
// Assumes it is bound into every sch_cmd_handler instance.
`timescale 1ns/10ps
module sch_cmd_handler_asserts import sch_pkg::*; #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Byte streams
  input wire sch_byte_s rx,
  input wire logic rx_ready,
  input wire sch_byte_s tx,
  input wire logic tx_ready,
  // Random source and converter
  input wire logic [15:0] rng_value,
  input wire logic adc_start,
  input wire logic [7:0] adc_channel,
  input wire logic [1:0] adc_resolution,
  input wire logic adc_done,
  input wire logic [15:0] adc_result,
  // Pins and power
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pullup,
  input wire logic sleep
);
  logic [7:0] idx_q;
  logic [7:0] len_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Position of the next reply byte within its frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 8'h00;
      len_q <= 8'h00;
    end else if (tx.valid && tx_ready) begin
      idx_q <= tx.last ? 8'h00 : idx_q + 8'h01;
      if (idx_q == 8'h00) begin
        len_q <= tx.data;
      end
    end
  end

  pin_reset_a: assert property ($rose(rst_b) |-> pin_oe == 4'h0 && pin_pullup == 4'hF && pin_out == 4'h0)
    else $error("pins not pulled-up inputs after reset");
  tx_hold_a: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data) && $stable(tx.last))
    else $error("reply byte changed before it was taken");
  adc_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("converter start longer than one cycle");
  rx_busy_a: assert property (tx.valid |-> !rx_ready)
    else $error("request accepted while replying");
  tri_only_a: assert property ((~$past(pin_oe[1:0]) & ~$past(pin_pullup[1:0]) & pin_pullup[1:0]) == 2'b00)
    else $error("pull-up raised on input pin zero or one");
  len_byte_a: assert property (tx.valid && idx_q == 8'h00 |-> tx.data inside {8'h01, 8'h02})
    else $error("bad reply length byte");
  hdr_byte_a: assert property (tx.valid && idx_q == 8'h01 |-> tx.data == 8'h61 || tx.data == 8'h41)
    else $error("bad reply header byte");
  last_byte_a: assert property (tx.valid && tx.last |-> idx_q == len_q + 8'h02)
    else $error("frame end does not match length byte");
endmodule : sch_cmd_handler_asserts

bind sch_cmd_handler sch_cmd_handler_asserts #(.MS_CYCLES(MS_CYCLES)) sch_cmd_handler_asserts_i (
  .clk, .rst_b, .rx, .rx_ready, .tx, .tx_ready, .rng_value, .adc_start, .adc_channel, .adc_resolution,
  .adc_done, .adc_result, .pin_in, .pin_out, .pin_oe, .pin_pullup, .sleep
);

// ===== testbench/sch_host_model.sv
// Host side model: sends request frames, collects reply bytes.
// Assumes the handler takes bytes on rx.valid and rx_ready at a rising edge.
`timescale 1ns/10ps
module sch_host_model import sch_pkg::*; (
  // Clock and control
  input wire logic clk,
  input wire logic slow,
  // Byte streams
  output sch_byte_s rx,
  input wire logic rx_ready,
  input wire sch_byte_s tx,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic [1:0] tick = 2'h0;

  initial begin
    rx = '0;
    tx_ready = 1'b1;
  end

  // Slow host takes one reply byte in four cycles
  always @(negedge clk) begin
    tick <= tick + 2'h1;
    tx_ready <= !slow || tick == 2'h0;
  end

  always @(posedge clk) begin
    if (tx.valid && tx_ready) begin
      got.push_back(tx.data);
    end
  end

  // Length byte first, then header and data, each held until taken
  task send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(negedge clk);
      rx <= '{valid: 1'b1, last: i == b.size() - 1, data: b[i]};
      #1;
      while (!rx_ready) begin
        @(negedge clk);
        #1;
      end
      @(posedge clk);
    end
    @(negedge clk);
    rx <= '{valid: 1'b0, last: 1'b0, data: ~rx.data};
  endtask : send
endmodule : sch_host_model

// ===== testbench/sch_cmd_handler_tb.sv
// Self-checking bench for the system command handler.
// Assumes the host model and a converter stub stand on the far sides.
`timescale 1ns/10ps
module sch_cmd_handler_tb;
  import sch_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  sch_byte_s rx;
  sch_byte_s tx;
  logic rx_ready;
  logic tx_ready;
  logic slow = 1'b0;
  logic sleep = 1'b0;
  logic adc_start;
  logic adc_done = 1'b0;
  logic [7:0] adc_channel;
  logic [1:0] adc_resolution;
  logic [15:0] rng_value = 16'hBEEF;
  logic [15:0] adc_result = 16'hF3A5;
  logic [3:0] ext = 4'h6;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic [3:0] pin_pullup;
  int err_count = 0;
  int checked = 0;
  logic [7:0] ch_t[5] = '{8'h06, 8'h07, 8'h0B, 8'h0E, 8'h0F};
  logic [39:0] nv_t[5] = '{40'h0403000200, 40'h05030E0200, 40'h0003010201, 40'h0603000101, 40'h0303010100};
  logic [7:0] op_t[8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h00, 8'h01};
  logic [7:0] mk_t[8] = '{8'h33, 8'h11, 8'h30, 8'h21, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic [3:0] pv_t[8] = '{4'h0, 4'h5, 4'h4, 4'hD, 4'hD, 4'hD, 4'h6, 4'h6};

  always #5 clk = ~clk;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  sch_cmd_handler #(.MS_CYCLES(10)) sch_cmd_handler_i (
    .clk, .rst_b, .rx, .rx_ready, .tx, .tx_ready, .rng_value, .adc_start, .adc_channel, .adc_resolution,
    .adc_done, .adc_result, .pin_in, .pin_out, .pin_oe, .pin_pullup, .sleep
  );
  sch_host_model sch_host_model_i (.clk, .slow, .rx, .rx_ready, .tx, .tx_ready);

  // Converter stub finishes four cycles after start, channel code as low result byte
  always @(negedge clk) begin
    if (adc_start) begin
      repeat (3) @(negedge clk);
      adc_result = {8'hF3, adc_channel};
      adc_done = 1'b1;
      @(negedge clk);
      adc_done = 1'b0;
    end
  end

  function automatic logic [7:0] pmap(input logic [3:0] p);
    return {2'b00, p[3:2], 2'b00, p[1:0]};
  endfunction : pmap

  task check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wait_reply(input logic [7:0] exp[$]);
    for (int n = 0; n < 3000 && sch_host_model_i.got.size() < exp.size(); n++) @(posedge clk);
    @(negedge clk);
    foreach (exp[i]) check(sch_host_model_i.got[i], exp[i]);
    check(8'(sch_host_model_i.got.size()), 8'(exp.size()));
    sch_host_model_i.got.delete();
  endtask : wait_reply

  task xfer(input logic [7:0] req[$], input logic [7:0] exp[$]);
    sch_host_model_i.send(req);
    wait_reply(exp);
  endtask : xfer

  task give_verdict;
    $display("Mismatches: %0d, comparisons: %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] req[$];
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check({pin_pullup, pin_oe}, 8'hF0);
    slow = 1'b1;
    xfer('{8'h00, 8'h21, 8'h0C}, '{8'h02, 8'h61, 8'h0C, 8'hEF, 8'hBE});
    slow = 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer('{8'h02, 8'h21, 8'h0D, ch_t[i], 8'(i % 4)}, '{8'h02, 8'h61, 8'h0D, ch_t[i], 8'hF3});
      check({adc_channel[3:0], 2'b00, adc_resolution}, {ch_t[i][3:0], 4'(i % 4)});
    end
    for (int i = 0; i < 5; i++) begin
      req = '{nv_t[i][15:8] + 8'h04, 8'h21, 8'h09, nv_t[i][39:32], nv_t[i][31:24], nv_t[i][23:16], nv_t[i][15:8]};
      repeat (nv_t[i][15:8]) req.push_back(8'h5A);
      xfer(req, '{8'h01, 8'h61, 8'h09, nv_t[i][7:0]});
    end
    // Fourth small item at offset 1, last big item at offset 14
    check(sch_cmd_handler_i.u_mem.mem_q[7], 8'h5A);
    check(sch_cmd_handler_i.u_mem.mem_q[38], 8'h5A);
    for (int i = 0; i < 4; i++) begin
      xfer('{8'h03, 8'h21, 8'h0A, 8'(i), 8'(20 + i * 10), 8'h00}, '{8'h01, 8'h61, 8'h0A, 8'h00});
    end
    for (int i = 0; i < 4; i++) wait_reply('{8'h01, 8'h41, 8'h81, 8'(i)});
    xfer('{8'h03, 8'h21, 8'h0A, 8'h04, 8'h01, 8'h00}, '{8'h01, 8'h61, 8'h0A, 8'h01});
    xfer('{8'h03, 8'h21, 8'h0A, 8'h01, 8'h05, 8'h00}, '{8'h01, 8'h61, 8'h0A, 8'h00});
    xfer('{8'h01, 8'h21, 8'h0B, 8'h01}, '{8'h01, 8'h61, 8'h0B, 8'h00});
    repeat (100) @(negedge clk);
    check(8'(sch_host_model_i.got.size()), 8'h00);
    for (int i = 0; i < 8; i++) begin
      sleep = i == 4;
      xfer('{8'h02, 8'h21, 8'h0E, op_t[i], mk_t[i]}, '{8'h01, 8'h61, 8'h0E, pmap(pv_t[i])});
      if (i == 0) check({4'h0, pin_oe}, 8'h0F);
    end
    check({4'h0, pin_pullup}, 8'h0C);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : sch_cmd_handler_tb
